// file: rtl/amr_pkg.sv
`default_nettype none
package amr_pkg;
    // Command opcodes
    localparam logic [7:0] OP_READ_MULT = 8'hc4;
    localparam logic [7:0] OP_READ_MULT_EXT = 8'h29;
    localparam logic [7:0] OP_NATIVE_MAX = 8'hf8;
    // Sector counts that a zero count field stands for
    localparam logic [16:0] ZERO_COUNT_28 = 17'h00100;
    localparam logic [16:0] ZERO_COUNT_48 = 17'h10000;
    // Largest address the 28-bit form can carry
    localparam logic [47:0] CAP_28 = 48'h00000fffffff;
    // Words per sector, last word index
    localparam logic [7:0] LAST_WORD = 8'hff;
    // Error register bit positions
    localparam int ERR_UNC = 6;
    localparam int ERR_IDNF = 4;
    localparam int ERR_ABRT = 2;
    // Status register bit positions
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    // Reset values
    localparam logic [7:0] ERROR_RESET = 8'h00;
    localparam logic [47:0] ADDR_RESET = 48'h000000000000;
    // Data path
    localparam int DATA_WIDTH = 16;
    localparam int FIFO_DEPTH = 16;
endpackage : amr_pkg
`default_nettype wire

// file: rtl/amr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module amr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic push;
    logic pop;

    // Full and empty come straight from the fill count
    assign in_ready_o = cnt != (AW+1)'(DEPTH);
    assign out_valid_o = cnt != '0;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rptr];

    // Storage has no reset; only the pointers and the fill count need a known value
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    // Pointers wrap at 2**AW, which matches the depth only when it is a power of two
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + AW'(1);
            end
            if (pop) begin
                rptr <= rptr + AW'(1);
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : amr_fifo
`default_nettype wire

// file: rtl/amr_top.sv
`timescale 1ns/100ps
`default_nettype none
module amr_top #(
    parameter int FIFO_WORDS = amr_pkg::FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cmd_we_i,
    input wire logic [7:0] cmd_i,
    input wire logic [7:0] sc_cur_i,
    input wire logic [7:0] sc_prev_i,
    input wire logic [7:0] sect_cur_i,
    input wire logic [7:0] cyl_lo_cur_i,
    input wire logic [7:0] cyl_hi_cur_i,
    input wire logic [7:0] sect_prev_i,
    input wire logic [7:0] cyl_lo_prev_i,
    input wire logic [7:0] cyl_hi_prev_i,
    input wire logic lba_mode_i,
    input wire logic [3:0] head_i,
    input wire logic hob_i,
    input wire logic [7:0] mult_count_i,
    input wire logic [47:0] native_max_i,
    input wire logic [15:0] max_cyl_i,
    input wire logic [3:0] max_head_i,
    input wire logic [7:0] max_sect_i,
    output logic [47:0] media_lba_o,
    output logic media_rd_o,
    input wire logic [amr_pkg::DATA_WIDTH-1:0] media_data_i,
    input wire logic media_valid_i,
    output logic media_ready_o,
    input wire logic media_unc_i,
    input wire logic media_idnf_i,
    output logic [amr_pkg::DATA_WIDTH-1:0] host_data_o,
    output logic host_valid_o,
    input wire logic host_ready_i,
    output logic intrq_o,
    output logic [7:0] status_o,
    output logic [7:0] error_o,
    output logic [7:0] sect_num_o,
    output logic [7:0] cyl_low_o,
    output logic [7:0] cyl_high_o,
    output logic [7:0] dev_head_o
);
    import amr_pkg::*;

    typedef enum logic {IDLE, XFER} amr_state_type;

    amr_state_type state;
    logic [16:0] sect_left;
    logic [7:0] word_cnt;
    logic [7:0] blk_cnt;
    logic [47:0] addr;
    logic [7:0] error;
    logic fifo_ready;
    logic beat;
    logic bad_beat;
    logic sector_end;
    logic block_end;
    logic start;

    // Zero in a count field means the largest count of that form
    function automatic logic [16:0] sector_count(input logic [15:0] field,
                                                 input logic [16:0] zero_val);
        sector_count = (field == 16'h0000) ? zero_val : {1'b0, field};
    endfunction : sector_count

    assign start = cmd_we_i && state == IDLE;
    assign media_ready_o = state == XFER && fifo_ready;
    assign beat = media_valid_i && media_ready_o;
    assign bad_beat = beat && (media_unc_i || media_idnf_i);
    assign sector_end = beat && !bad_beat && word_cnt == LAST_WORD;
    // A zero multiple count is read as one sector per block
    assign block_end = sector_end
        && (blk_cnt + 8'h01 >= mult_count_i || sect_left == 17'h00001);
    assign media_rd_o = state == XFER;
    assign media_lba_o = addr;

    // Words go through the buffer so a slow host stalls the media side
    amr_fifo #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(beat && !bad_beat),
        .in_ready_o(fifo_ready),
        .in_data_i(media_data_i),
        .out_valid_o(host_valid_o),
        .out_ready_i(host_ready_i),
        .out_data_o(host_data_o)
    );

    // Command decode and transfer sequencing
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= IDLE;
            sect_left <= '0;
        end else if (start) begin
            unique case (cmd_i)
                OP_READ_MULT: begin
                    sect_left <= sector_count({8'h00, sc_cur_i},
                                              ZERO_COUNT_28);
                    state <= XFER;
                end
                OP_READ_MULT_EXT: begin
                    sect_left <= sector_count({sc_prev_i, sc_cur_i},
                                              ZERO_COUNT_48);
                    state <= XFER;
                end
                default: state <= IDLE;
            endcase
        end else if (state == XFER) begin
            if (bad_beat) begin
                state <= IDLE;
            end else if (sector_end) begin
                sect_left <= sect_left - 17'h00001;
                if (sect_left == 17'h00001) begin
                    state <= IDLE;
                end
            end
        end
    end

    // Word and block counters within the transfer
    always_ff @(posedge mclk_i) begin
        if (rst_i || start) begin
            word_cnt <= '0;
            blk_cnt <= '0;
        end else if (beat && !bad_beat) begin
            word_cnt <= word_cnt + 8'h01;
            if (block_end) begin
                blk_cnt <= '0;
            end else if (sector_end) begin
                blk_cnt <= blk_cnt + 8'h01;
            end
        end
    end

    // Address register: start address, then running, failing or native max
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            addr <= ADDR_RESET;
        end else if (start && cmd_i == OP_READ_MULT) begin
            addr <= {20'h00000, head_i, cyl_hi_cur_i, cyl_lo_cur_i,
                     sect_cur_i};
        end else if (start && cmd_i == OP_READ_MULT_EXT) begin
            addr <= {cyl_hi_prev_i, cyl_lo_prev_i, sect_prev_i,
                     cyl_hi_cur_i, cyl_lo_cur_i, sect_cur_i};
        end else if (start && cmd_i == OP_NATIVE_MAX) begin
            // LBA mode reads native_max_i, capped at CAP_28; CHS mode reads max_cyl_i, max_head_i and max_sect_i
            if (!lba_mode_i) begin
                addr <= {20'h00000, max_head_i, max_cyl_i,
                         max_sect_i};
            end else if (native_max_i > CAP_28) begin
                addr <= CAP_28;
            end else begin
                addr <= native_max_i;
            end
        end else if (sector_end && sect_left != 17'h00001) begin
            // Not advanced on the failing sector, so it stays reported
            addr <= addr + 48'h000000000001;
        end
    end

    // Error register cleared by each new command
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            error <= ERROR_RESET;
        end else if (start) begin
            error <= ERROR_RESET;
            if (cmd_i != OP_READ_MULT && cmd_i != OP_READ_MULT_EXT
                && cmd_i != OP_NATIVE_MAX) begin
                error[ERR_ABRT] <= 1'b1;
            end
        end else if (bad_beat) begin
            error[ERR_UNC] <= media_unc_i;
            error[ERR_IDNF] <= media_idnf_i && !media_unc_i;
        end
    end

    // One pulse per block, per error stop and per non-transfer command
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            intrq_o <= 1'b0;
        end else begin
            intrq_o <= block_end || bad_beat
                || (start && cmd_i != OP_READ_MULT
                    && cmd_i != OP_READ_MULT_EXT);
        end
    end

    // Status and address readback; HOB picks the high half
    assign error_o = error;
    assign status_o = {state == XFER, 1'b1, 1'b0, 1'b1, host_valid_o,
                       2'b00, error != ERROR_RESET};
    assign sect_num_o = hob_i ? addr[31:24] : addr[7:0];
    assign cyl_low_o = hob_i ? addr[39:32] : addr[15:8];
    assign cyl_high_o = hob_i ? addr[47:40] : addr[23:16];
    assign dev_head_o = {4'h0, addr[27:24]};

    chk_count_28: assert property (@(posedge mclk_i) disable iff (rst_i)
        start && cmd_i == OP_READ_MULT && sc_cur_i == 8'h00
        |=> sect_left == ZERO_COUNT_28 && state == XFER)
        else $error("zero 28-bit count not 256");
    chk_count_48: assert property (@(posedge mclk_i) disable iff (rst_i)
        start && cmd_i == OP_READ_MULT_EXT && {sc_prev_i, sc_cur_i} == 16'h0
        |=> sect_left == ZERO_COUNT_48)
        else $error("zero 48-bit count not 65536");
    chk_lba_48: assert property (@(posedge mclk_i) disable iff (rst_i)
        start && cmd_i == OP_READ_MULT_EXT
        |=> addr[47:40] == $past(cyl_hi_prev_i)
            && addr[7:0] == $past(sect_cur_i))
        else $error("48-bit start address misassembled");
    chk_cap_native: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        start && cmd_i == OP_NATIVE_MAX && lba_mode_i
        && native_max_i > CAP_28 |=> addr == CAP_28 ##1 intrq_o == 1'b0)
        else $error("native max not capped");
    chk_chs_head: assert property (@(posedge mclk_i) disable iff (rst_i)
        start && cmd_i == OP_NATIVE_MAX && !lba_mode_i
        |=> dev_head_o[3:0] == $past(max_head_i) && intrq_o)
        else $error("chs head not returned");
    chk_unc_stop: assert property (@(posedge mclk_i) disable iff (rst_i)
        bad_beat && media_unc_i
        |=> state == IDLE && error[ERR_UNC] && status_o[ST_ERR]
            && intrq_o && $stable(addr))
        else $error("transfer not stopped on error");
    chk_abort_cmd: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        start && cmd_i == 8'h00 |=> error_o == 8'h04 ##1 state == IDLE)
        else $error("unknown command not aborted");
    chk_block_irq: assert property (@(posedge mclk_i) disable iff (rst_i)
        sector_end && !block_end |=> !intrq_o)
        else $error("interrupt raised mid-block");
    // Every end of busy, clean or cut short, must come with its interrupt
    chk_busy_xfer: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        $fell(status_o[ST_BSY]) |-> intrq_o && !media_rd_o)
        else $error("busy ended without interrupt");
endmodule : amr_top
`default_nettype wire

// file: testbench/amr_media_model.sv
`timescale 1ns/100ps
`default_nettype none
// Media side: 256 words per sector, each word carries the low
// address byte of its sector and its index within the sector
module amr_media_model (
    input wire logic mclk_i,
    input wire logic rd_i,
    input wire logic ready_i,
    input wire logic [47:0] lba_i,
    input wire logic slow_i,
    input wire logic fail_i,
    input wire logic idnf_i,
    input wire logic [47:0] fail_lba_i,
    output logic [15:0] data_o,
    output logic valid_o,
    output logic unc_o,
    output logic idnf_o
);
    logic [7:0] word = 8'h00;
    logic taken = 1'b0;
    logic nv;
    initial begin
        data_o = 16'h0000;
        valid_o = 1'b0;
        unc_o = 1'b0;
        idnf_o = 1'b0;
    end
    // Index moves only on an accepted beat
    always @(posedge mclk_i) begin
        taken <= valid_o && ready_i;
        if (!rd_i)
            word <= 8'h00;
        else if (valid_o && ready_i)
            word <= word + 8'h01;
    end
    // A word is held until taken; slow mode leaves a gap after each
    always @(negedge mclk_i) begin
        if (!(valid_o && !taken && rd_i)) begin
            nv = rd_i && !(slow_i && valid_o);
            valid_o <= nv;
            // Idle lines show inverted data so a stale word never matches
            data_o <= nv ? {lba_i[7:0], word} : ~data_o;
            unc_o <= nv && fail_i && !idnf_i && lba_i == fail_lba_i;
            idnf_o <= nv && fail_i && idnf_i && lba_i == fail_lba_i;
        end
    end
endmodule : amr_media_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import amr_pkg::*;
    logic clk = '0, rst = 1'b1, we = '0, lm = '0, hob = '0, hrdy = '0;
    logic hold = '0, hstall = '0, slow = '0, fl = '0, fi = '0;
    logic mrd, mv, mr, mu, mi, hv, irq;
    logic [7:0] cmd = '0, scc = '0, scp = '0, mult = 8'h01, ew = '0;
    logic [7:0] ms = 8'h3c, st, err, sn, cl, ch, dh;
    logic [15:0] mcyl = 16'h1a2b, md, hd;
    logic [3:0] mh = 4'h7;
    logic [47:0] la = '0, nm = '0, flba = '0, elba = '0, mlba;
    int n_errors = 0, check_count = 0, cyc = 0, nirq = 0, nw = 0;
    amr_top dut_u (
        .mclk_i(clk), .rst_i(rst), .cmd_we_i(we), .cmd_i(cmd),
        .sc_cur_i(scc), .sc_prev_i(scp), .sect_cur_i(la[7:0]),
        .cyl_lo_cur_i(la[15:8]), .cyl_hi_cur_i(la[23:16]),
        .sect_prev_i(la[31:24]), .cyl_lo_prev_i(la[39:32]),
        .cyl_hi_prev_i(la[47:40]), .lba_mode_i(lm), .head_i(la[27:24]),
        .hob_i(hob), .mult_count_i(mult), .native_max_i(nm),
        .max_cyl_i(mcyl), .max_head_i(mh), .max_sect_i(ms),
        .media_lba_o(mlba), .media_rd_o(mrd), .media_data_i(md),
        .media_valid_i(mv), .media_ready_o(mr), .media_unc_i(mu),
        .media_idnf_i(mi), .host_data_o(hd), .host_valid_o(hv),
        .host_ready_i(hrdy), .intrq_o(irq), .status_o(st), .error_o(err),
        .sect_num_o(sn), .cyl_low_o(cl), .cyl_high_o(ch), .dev_head_o(dh)
    );
    amr_media_model media_u (
        .mclk_i(clk), .rd_i(mrd), .ready_i(mr), .lba_i(mlba),
        .slow_i(slow), .fail_i(fl), .idnf_i(fi), .fail_lba_i(flba),
        .data_o(md), .valid_o(mv), .unc_o(mu), .idnf_o(mi)
    );
    // 25 MHz clock
    always #20 clk = ~clk;
    // Host stalls every other cycle, or fully to fill the buffer
    always @(negedge clk)
        hrdy <= hold ? 1'b0 : (hstall ? ~hrdy : 1'b1);
    task automatic chk(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    // Count interrupt pulses and check each popped word; cut a hang
    always @(posedge clk) begin
        cyc++;
        if (irq === 1'b1)
            nirq++;
        if (hv === 1'b1 && hrdy === 1'b1) begin
            chk("host word", 48'(hd), 48'({elba[7:0], ew}));
            nw++;
            ew++;
            if (ew == 8'h00)
                elba++;
        end
        if (cyc == 90000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic go(input logic [7:0] op);
        @(negedge clk);
        cmd = op;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask : go
    // Busy may hold for a whole 257-sector run, so the bound is generous
    task automatic idle;
        int k;
        k = 0;
        while ((st[ST_BSY] !== 1'b0 || hv !== 1'b0) && k < 80000) begin
            @(negedge clk);
            k++;
        end
        repeat (2) @(negedge clk);
        chk("bounded wait", 48'(k < 80000), 48'h1);
    endtask : idle
    task automatic nmx(input logic l, input logic [47:0] v,
                       input logic [31:0] e);
        lm = l;
        nm = v;
        nirq = 0;
        go(OP_NATIVE_MAX);
        idle();
        chk("irqs", 48'(nirq), 48'h1);
        chk("error", 48'(err), 48'h0);
        chk("native max", 48'({dh, ch, cl, sn}), 48'(e));
        $display("native max test done, mode %0d", l);
    endtask : nmx
    // An opcode outside the three is refused with an abort
    task automatic bad_op;
        nirq = 0;
        go(8'h00);
        idle();
        chk("bad opcode error", 48'(err), 48'h4);
        chk("bad opcode status", 48'(st), 48'h51);
        chk("bad opcode irqs", 48'(nirq), 48'h1);
        $display("bad opcode test done");
    endtask : bad_op
    task automatic rd(input logic [7:0] op, input logic [15:0] cnt,
                      input logic [47:0] a, input logic [7:0] m,
                      input int ns, input int nb, input int fs,
                      input logic [7:0] ee);
        logic [47:0] e;
        la = a;
        scc = cnt[7:0];
        scp = cnt[15:8];
        mult = m;
        elba = a;
        ew = '0;
        nw = 0;
        nirq = 0;
        fl = fs < ns;
        flba = a + 48'(fs);
        e = fl ? flba : a + 48'(ns - 1);
        go(op);
        if (hold) begin
            repeat (40) @(negedge clk);
            chk("ready while full", 48'(mr), 48'h0);
            chk("words while full", 48'(nw), 48'h0);
            hold = 1'b0;
        end
        idle();
        chk("words", 48'(nw), 48'(fl ? fs * 256 : ns * 256));
        chk("irqs", 48'(nirq), 48'(nb));
        chk("error", 48'(err), 48'(ee));
        chk("status", 48'(st), 48'({7'h28, ee != 8'h00}));
        chk("address", 48'({dh, ch, cl, sn}), 48'(e[27:0]));
        hob = 1'b1;
        #1;
        chk("address upper", 48'({ch, cl, sn}), 48'(e[47:24]));
        hob = 1'b0;
        $display("read test done, opcode %h", op);
    endtask : rd
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("status after reset", 48'(st), 48'h50);
        nmx(1'b1, 48'h0001_2345_6789, 32'h0fff_ffff);
        nmx(1'b1, 48'h0000_0abc_def1, 32'h0abc_def1);
        nmx(1'b0, 48'h0000_0abc_def1, 32'h071a_2b3c);
        bad_op();
        hold = 1'b1;
        rd(OP_READ_MULT, 16'h0002, 48'h0000_0abc_defe, 8'h01, 2, 2, 9, 8'h00);
        slow = 1'b1;
        hstall = 1'b1;
        rd(OP_READ_MULT, 16'h0005, 48'h0000_0123_4567, 8'h02, 5, 3, 9, 8'h00);
        slow = 1'b0;
        hstall = 1'b0;
        rd(OP_READ_MULT_EXT, 16'h0101, 48'h9876_5432_10ff, 8'h10,
           257, 17, 999, 8'h00);
        for (int i = 0; i < 2; i++) begin
            fi = i[0];
            rd(OP_READ_MULT_EXT, 16'h0003, 48'h1122_3344_5566, 8'h01,
               3, 2, 1, fi ? 8'h10 : 8'h40);
        end
        // Zero counts, cut short by an error after the first sector
        fi = 1'b0;
        rd(OP_READ_MULT, 16'h0000, 48'h0000_0765_4321, 8'h01,
           256, 2, 1, 8'h40);
        rd(OP_READ_MULT_EXT, 16'h0000, 48'h0a0b_0c0d_0e0f, 8'h01,
           65536, 2, 1, 8'h40);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
